// File: include/fpm_consts.svh
// Constants for the field unit point map decoder: locations, fields, register map
`ifndef FPM_CONSTS_SVH
`define FPM_CONSTS_SVH

// Field unit population
`define FPM_NUM_UNITS        240
`define FPM_UNIT_SPAN        16'h00F0
`define FPM_UNIT_W           8
`define FPM_ADDR_W           16
`define FPM_DATA_W           16

// Host function codes
`define FPM_FC_READ_DISC     8'h02
`define FPM_FC_WRITE_COIL    8'h05
`define FPM_FC_WRITE_MULTI   8'h0F
`define FPM_EXC_ILLEGAL_ADDR 8'h02
`define FPM_EXC_NONE         8'h00

// Discrete input bases; location = base + unit
`define FPM_DISC_OBS_BASE    16'h3E90
`define FPM_DISC_JAM_BASE    16'h3F80
`define FPM_DISC_AUX_BASE    16'h4070
`define FPM_DISC_TRV_BASE    16'h4160
`define FPM_DISC_B26_BASE    16'h4250
`define FPM_DISC_MANU_BASE   16'h4340
`define FPM_DISC_LIMIT_BASE  16'h4430
`define FPM_DISC_RLY4_BASE   16'h4520
`define FPM_DISC_RLY1_BASE   16'h4610
`define FPM_DISC_RLY3_BASE   16'h4700
`define FPM_DISC_RLY2_BASE   16'h47F0
`define FPM_DISC_GROUPS      11
`define FPM_DISC_ALARM_GRPS  4'h7
`define FPM_GRP_W            4

// Coil locations
`define FPM_COIL_PAIR_BASE   16'h0020
`define FPM_COIL_PAIR_FIRST  16'h0021
`define FPM_COIL_PAIR_LAST   16'h0200
`define FPM_COIL_OPEN_BASE   16'h0200
`define FPM_COIL_STOP_BASE   16'h02F0
`define FPM_COIL_CLOSE_BASE  16'h03E0
`define FPM_COIL_SHUT_BASE   16'h04D0
`define FPM_COIL_ALIAS_LAST  16'h05C0

// Relay index on the command port: relay number minus one
`define FPM_RLY_CLOSE        2'h0
`define FPM_RLY_OPEN         2'h1
`define FPM_RLY_STOP         2'h2
`define FPM_RLY_SHUT         2'h3

// Point store word: bits 6..0 alarms 22..28, 10..7 relay coils, 11 general purpose
`define FPM_STORE_W          12
`define FPM_STORE_GP_BIT     11

// Software register indices and fields
`define FPM_REG_ADDR_W       2
`define FPM_REG_CTRL         2'h0
`define FPM_REG_STATUS       2'h1
`define FPM_REG_MASK         2'h2
`define FPM_REG_LAST_CMD     2'h3
`define FPM_CTRL_EN_BIT      0
`define FPM_CTRL_RESET       1'h1
`define FPM_EVT_W            3
`define FPM_EVT_CMD          0
`define FPM_EVT_ILLEGAL      1
`define FPM_EVT_FIELD        2
`define FPM_LAST_CMD_W       11

`endif

// File: include/fpm_pkg.sv
// Types shared by the field unit point map decoder
`default_nettype none
`include "fpm_consts.svh"

package fpm_pkg;

   typedef enum logic [0:0]
   {
      ST_IDLE   = 1'b0,
      ST_ACCESS = 1'b1
   } fpm_state_e;

   typedef struct packed
   {
      fpm_state_e                 state;
      logic                       req_ready;
      logic                       rsp_valid;
      logic                       rsp_bit;
      logic                       rsp_exc;
      logic [7:0]                 rsp_code;
      logic                       acc_legal;
      logic                       acc_read;
      logic [`FPM_GRP_W-1:0]      acc_grp;
      logic [`FPM_UNIT_W-1:0]     acc_unit;
      logic [1:0]                 acc_relay;
      logic                       acc_on;
      logic                       cmd_valid;
      logic [`FPM_UNIT_W-1:0]     cmd_unit;
      logic [1:0]                 cmd_relay;
      logic                       cmd_on;
      logic                       ctrl_en;
      logic [`FPM_EVT_W-1:0]      status;
      logic [`FPM_EVT_W-1:0]      mask;
      logic [`FPM_LAST_CMD_W-1:0] last_cmd;
      logic [`FPM_DATA_W-1:0]     rdata;
      logic                       irq;
   } fpm_state_s;

endpackage
`default_nettype wire

// File: hdl/fpm_addr_decode.sv
// Location and function code decoder for discrete inputs and relay command coils
`timescale 1ns/10ps
`default_nettype none
`include "fpm_consts.svh"

module fpm_addr_decode
(
   input  wire logic [7:0]              i_func,
   input  wire logic [`FPM_ADDR_W-1:0]  i_addr,
   output logic                         o_legal,
   output logic                         o_read,
   output logic [`FPM_GRP_W-1:0]        o_grp,
   output logic [`FPM_UNIT_W-1:0]       o_unit,
   output logic [1:0]                   o_relay
);

   // Base of a discrete group in location order
   function automatic logic [`FPM_ADDR_W-1:0] disc_base(input logic [`FPM_GRP_W-1:0] grp);
      logic [`FPM_ADDR_W-1:0] b;
      b = `FPM_DISC_OBS_BASE;
      unique case (grp)
         4'h0:    b = `FPM_DISC_OBS_BASE;
         4'h1:    b = `FPM_DISC_JAM_BASE;
         4'h2:    b = `FPM_DISC_AUX_BASE;
         4'h3:    b = `FPM_DISC_TRV_BASE;
         4'h4:    b = `FPM_DISC_B26_BASE;
         4'h5:    b = `FPM_DISC_MANU_BASE;
         4'h6:    b = `FPM_DISC_LIMIT_BASE;
         4'h7:    b = `FPM_DISC_RLY4_BASE;
         4'h8:    b = `FPM_DISC_RLY1_BASE;
         4'h9:    b = `FPM_DISC_RLY3_BASE;
         4'hA:    b = `FPM_DISC_RLY2_BASE;
         default: b = `FPM_DISC_OBS_BASE;
      endcase
      return b;
   endfunction

   // Alias coil bands in location order: open, stop, close, shutdown
   function automatic logic [`FPM_ADDR_W-1:0] alias_base(input logic [1:0] k);
      logic [`FPM_ADDR_W-1:0] b;
      b = `FPM_COIL_OPEN_BASE;
      unique case (k)
         2'h0: b = `FPM_COIL_OPEN_BASE;
         2'h1: b = `FPM_COIL_STOP_BASE;
         2'h2: b = `FPM_COIL_CLOSE_BASE;
         2'h3: b = `FPM_COIL_SHUT_BASE;
      endcase
      return b;
   endfunction

   function automatic logic [1:0] alias_relay(input logic [1:0] k);
      logic [1:0] r;
      r = `FPM_RLY_OPEN;
      unique case (k)
         2'h0: r = `FPM_RLY_OPEN;
         2'h1: r = `FPM_RLY_STOP;
         2'h2: r = `FPM_RLY_CLOSE;
         2'h3: r = `FPM_RLY_SHUT;
      endcase
      return r;
   endfunction

   // True when addr lies in base+1 .. base+240
   function automatic logic in_band(input logic [`FPM_ADDR_W-1:0] addr,
                                    input logic [`FPM_ADDR_W-1:0] base);
      return (addr > base) && (addr <= base + `FPM_UNIT_SPAN);
   endfunction

   logic                     is_disc_fc;
   logic                     is_coil_fc;
   logic [`FPM_ADDR_W-1:0]   pair_off;
   logic [`FPM_ADDR_W-1:0]   unit_wide;

   assign is_disc_fc = (i_func == `FPM_FC_READ_DISC);
   assign is_coil_fc = (i_func == `FPM_FC_WRITE_COIL) || (i_func == `FPM_FC_WRITE_MULTI);
   assign pair_off   = i_addr - `FPM_COIL_PAIR_FIRST;

   always_comb
   begin
      o_legal   = 1'b0;
      o_read    = is_disc_fc;
      o_grp     = '0;
      o_relay   = `FPM_RLY_CLOSE;
      unit_wide = '0;
      if (is_disc_fc)
      begin
         for (int g = 0; g < `FPM_DISC_GROUPS; g++)
         begin
            if (in_band(i_addr, disc_base(g[`FPM_GRP_W-1:0])))
            begin
               o_legal   = 1'b1;
               o_grp     = g[`FPM_GRP_W-1:0];
               unit_wide = i_addr - disc_base(g[`FPM_GRP_W-1:0]);
            end
         end
      end
      else if (is_coil_fc)
      begin
         if ((i_addr >= `FPM_COIL_PAIR_FIRST) && (i_addr <= `FPM_COIL_PAIR_LAST))
         begin
            // Odd location closes, the even one after it opens
            o_legal   = 1'b1;
            o_relay   = pair_off[0] ? `FPM_RLY_OPEN : `FPM_RLY_CLOSE;
            unit_wide = {1'b0, pair_off[`FPM_ADDR_W-1:1]} + 16'h0001;
         end
         for (int k = 0; k < 4; k++)
         begin
            if (in_band(i_addr, alias_base(k[1:0])))
            begin
               o_legal   = 1'b1;
               o_relay   = alias_relay(k[1:0]);
               unit_wide = i_addr - alias_base(k[1:0]);
            end
         end
      end
      o_unit = unit_wide[`FPM_UNIT_W-1:0];
   end

endmodule
`default_nettype wire

// File: hdl/fpm_point_map.sv
// Field unit point map: discrete input server, relay command coils, software registers
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "fpm_consts.svh"

// Notes on behaviour
// - Alarms and coil status are read-only discretes
// - Unit number runs 1 to 240 inclusive
// - Alarm bits 22 to 27 from 16016+N onward
// - End of travel alarm at 17456 plus N
// - Relay 4, 1, 3 coil status bases
// - Relay 2 status at 18416+N, general units
// - Coil status read one discrete at a time
// - Accept single and multiple coil writes
// - Nonzero write energises the addressed relay
// - Zero write de-energises the addressed relay
// - Close at 32+2N-1, open at 32+2N
// - Alias block from 513 to 1472
// - Alias open, stop, close, shutdown bands
module fpm_point_map
#(
   parameter int NUM_UNITS = `FPM_NUM_UNITS
)
(
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rst_n,
   // Host request, one point per request
   input  wire logic                        i_req_valid,
   input  wire logic [7:0]                  i_req_func,
   input  wire logic [`FPM_ADDR_W-1:0]      i_req_addr,
   input  wire logic [`FPM_DATA_W-1:0]      i_req_wdata,
   output logic                             o_req_ready,
   output logic                             o_rsp_valid,
   output logic                             o_rsp_bit,
   output logic                             o_rsp_exc,
   output logic [7:0]                       o_rsp_exc_code,
   // Field network point updates
   input  wire logic                        i_fld_wr,
   input  wire logic [`FPM_UNIT_W-1:0]      i_fld_unit,
   input  wire logic [6:0]                  i_fld_alarm,
   input  wire logic [3:0]                  i_fld_relay,
   input  wire logic                        i_fld_gp,
   // Relay commands toward the field network
   output logic                             o_cmd_valid,
   output logic [`FPM_UNIT_W-1:0]           o_cmd_unit,
   output logic [1:0]                       o_cmd_relay,
   output logic                             o_cmd_on,
   // Software register port
   input  wire logic [`FPM_REG_ADDR_W-1:0]  i_reg_addr,
   input  wire logic [`FPM_DATA_W-1:0]      i_reg_wdata,
   input  wire logic                        i_reg_wr,
   input  wire logic                        i_reg_rd,
   output logic [`FPM_DATA_W-1:0]           o_reg_rdata,
   output logic                             o_irq
);

   fpm_pkg::fpm_state_s                 st_reg;
   fpm_pkg::fpm_state_s                 st_next;

   // Point store, one word per field unit
   logic [`FPM_STORE_W-1:0]             store_mem [NUM_UNITS];
   logic [NUM_UNITS-1:0]                seen_reg;

   logic                                dec_legal;
   logic                                dec_read;
   logic [`FPM_GRP_W-1:0]               dec_grp;
   logic [`FPM_UNIT_W-1:0]              dec_unit;
   logic [1:0]                          dec_relay;

   logic                                fld_ok;
   logic [`FPM_UNIT_W-1:0]              fld_idx;
   logic [`FPM_STORE_W-1:0]             fld_word;
   logic [`FPM_UNIT_W-1:0]              acc_idx;
   logic [`FPM_STORE_W-1:0]             rd_word;
   logic [`FPM_EVT_W-1:0]               evt_set;
   logic [`FPM_EVT_W-1:0]               evt_clr;

   // Unit number to store index; caller guarantees 1..NUM_UNITS
   function automatic logic [`FPM_UNIT_W-1:0] unit_index(input logic [`FPM_UNIT_W-1:0] unit);
      return unit - 8'h01;
   endfunction

   function automatic logic unit_in_range(input logic [`FPM_UNIT_W-1:0] unit);
      return (unit != 8'h00) && (32'(unit) <= NUM_UNITS);
   endfunction

   fpm_addr_decode u_decode
   (
      .i_func  (i_req_func),
      .i_addr  (i_req_addr),
      .o_legal (dec_legal),
      .o_read  (dec_read),
      .o_grp   (dec_grp),
      .o_unit  (dec_unit),
      .o_relay (dec_relay)
   );

   // Store word laid out in discrete group order: relays 4, 1, 3, 2 above the alarms
   assign fld_ok   = i_fld_wr && unit_in_range(i_fld_unit);
   assign fld_idx  = unit_index(i_fld_unit);
   assign fld_word = {i_fld_gp, i_fld_relay[1], i_fld_relay[2], i_fld_relay[0],
                      i_fld_relay[3], i_fld_alarm};

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         seen_reg <= '0;
      end
      else if (fld_ok)
      begin
         seen_reg[fld_idx] <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (fld_ok)
      begin
         store_mem[fld_idx] <= fld_word;
      end
   end

   // Units never reported read as all clear
   assign acc_idx = unit_index(st_reg.acc_unit);
   always_comb
   begin
      rd_word = '0;
      if (st_reg.acc_legal && st_reg.acc_read && seen_reg[acc_idx])
      begin
         rd_word = store_mem[acc_idx];
      end
   end

   // Software write-one-to-clear of status bits
   assign evt_clr = (i_reg_wr && (i_reg_addr == `FPM_REG_STATUS)) ?
                    i_reg_wdata[`FPM_EVT_W-1:0] : '0;

   always_comb
   begin
      st_next           = st_reg;
      st_next.rsp_valid = 1'b0;
      st_next.cmd_valid = 1'b0;
      st_next.rdata     = '0;
      evt_set           = '0;
      evt_set[`FPM_EVT_FIELD] = fld_ok;

      unique case (st_reg.state)
         fpm_pkg::ST_IDLE:
         begin
            if (i_req_valid)
            begin
               st_next.acc_legal = dec_legal;
               st_next.acc_read  = dec_read;
               st_next.acc_grp   = dec_grp;
               st_next.acc_unit  = dec_unit;
               st_next.acc_relay = dec_relay;
               st_next.acc_on    = (i_req_wdata != 16'h0000);
               st_next.state     = fpm_pkg::ST_ACCESS;
            end
         end
         fpm_pkg::ST_ACCESS:
         begin
            st_next.state     = fpm_pkg::ST_IDLE;
            st_next.rsp_valid = 1'b1;
            if (!st_reg.acc_legal)
            begin
               st_next.rsp_exc  = 1'b1;
               st_next.rsp_code = `FPM_EXC_ILLEGAL_ADDR;
               st_next.rsp_bit  = 1'b0;
               evt_set[`FPM_EVT_ILLEGAL] = 1'b1;
            end
            else if (st_reg.acc_read)
            begin
               st_next.rsp_exc  = 1'b0;
               st_next.rsp_code = `FPM_EXC_NONE;
               // Coil status only counts for general purpose units
               if (st_reg.acc_grp < `FPM_DISC_ALARM_GRPS)
               begin
                  st_next.rsp_bit = rd_word[st_reg.acc_grp];
               end
               else
               begin
                  st_next.rsp_bit = rd_word[st_reg.acc_grp] &
                                    rd_word[`FPM_STORE_GP_BIT];
               end
            end
            else
            begin
               // Coil write echoes the written state
               st_next.rsp_exc  = 1'b0;
               st_next.rsp_code = `FPM_EXC_NONE;
               st_next.rsp_bit  = st_reg.acc_on;
               if (st_reg.ctrl_en)
               begin
                  // Each write is a one-shot command; nothing waits for a clear
                  st_next.cmd_valid = 1'b1;
                  st_next.cmd_unit  = st_reg.acc_unit;
                  st_next.cmd_relay = st_reg.acc_relay;
                  st_next.cmd_on    = st_reg.acc_on;
                  st_next.last_cmd  = {st_reg.acc_on, st_reg.acc_relay, st_reg.acc_unit};
                  evt_set[`FPM_EVT_CMD] = 1'b1;
               end
            end
         end
      endcase

      st_next.req_ready = (st_next.state == fpm_pkg::ST_IDLE);

      // Register writes
      if (i_reg_wr)
      begin
         unique case (i_reg_addr)
            `FPM_REG_CTRL:     st_next.ctrl_en = i_reg_wdata[`FPM_CTRL_EN_BIT];
            `FPM_REG_MASK:     st_next.mask    = i_reg_wdata[`FPM_EVT_W-1:0];
            `FPM_REG_STATUS:   st_next.status  = st_reg.status;
            `FPM_REG_LAST_CMD: st_next.last_cmd = st_next.last_cmd;
         endcase
      end

      // New events win over a clear in the same cycle
      st_next.status = (st_reg.status & ~evt_clr) | evt_set;
      st_next.irq    = |(st_next.status & st_next.mask);

      // Read data stands only in the cycle after the strobe
      if (i_reg_rd)
      begin
         unique case (i_reg_addr)
            `FPM_REG_CTRL:
               st_next.rdata = {15'h0000, st_reg.ctrl_en};
            `FPM_REG_STATUS:
               st_next.rdata = {13'h0000, st_reg.status};
            `FPM_REG_MASK:
               st_next.rdata = {13'h0000, st_reg.mask};
            `FPM_REG_LAST_CMD:
               st_next.rdata = {5'h00, st_reg.last_cmd};
         endcase
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         st_reg           <= '0;
         st_reg.req_ready <= 1'b1;
         st_reg.ctrl_en   <= `FPM_CTRL_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_req_ready    = st_reg.req_ready;
   assign o_rsp_valid    = st_reg.rsp_valid;
   assign o_rsp_bit      = st_reg.rsp_bit;
   assign o_rsp_exc      = st_reg.rsp_exc;
   assign o_rsp_exc_code = st_reg.rsp_code;
   assign o_cmd_valid    = st_reg.cmd_valid;
   assign o_cmd_unit     = st_reg.cmd_unit;
   assign o_cmd_relay    = st_reg.cmd_relay;
   assign o_cmd_on       = st_reg.cmd_on;
   assign o_reg_rdata    = st_reg.rdata;
   assign o_irq          = st_reg.irq;

endmodule
`default_nettype wire

// File: tb/fpm_point_map_properties.sv
// Assertions on the host request, answer and relay command ports
`timescale 1ns/10ps
`default_nettype none
module fpm_point_map_properties
#(
   parameter int NUM_UNITS = 240
)
(
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic        i_req_valid,
   input wire logic [7:0]  i_req_func,
   input wire logic [15:0] i_req_addr,
   input wire logic [15:0] i_req_wdata,
   input wire logic        o_req_ready,
   input wire logic        o_rsp_valid,
   input wire logic        o_rsp_bit,
   input wire logic        o_rsp_exc,
   input wire logic [7:0]  o_rsp_exc_code,
   input wire logic        o_cmd_valid,
   input wire logic [7:0]  o_cmd_unit,
   input wire logic [1:0]  o_cmd_relay,
   input wire logic        o_cmd_on
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   logic take;
   logic wr;
   assign take = i_req_valid && o_req_ready;
   assign wr = take && (i_req_func == 8'h05 || i_req_func == 8'h0F);

   property pair_p;
      logic [15:0] a;
      (wr && i_req_addr inside {[16'h0021:16'h0200]}, a = i_req_addr) |-> ##2 (!o_rsp_exc
         && (!o_cmd_valid || (o_cmd_unit == 8'((a - 16'h001F) >> 1)
         && o_cmd_relay == {1'b0, ~a[0]})));
   endproperty
   // Bands of 240 in the order open, stop, close, shutdown
   property alias_p;
      logic [15:0] o;
      (wr && i_req_addr inside {[16'h0201:16'h05C0]}, o = i_req_addr - 16'h0201)
         |-> ##2 (!o_rsp_exc && (!o_cmd_valid || (o_cmd_unit == 8'(o % 240 + 1)
         && o_cmd_relay == 2'(8'hC9 >> (2 * (o / 240))))));
   endproperty

   ready_drop_a: assert property (take |=> !o_req_ready) else $error("ready held after take");
   rsp_latency_a: assert property (take |-> ##2 o_rsp_valid) else $error("answer late");
   rsp_pulse_a: assert property (o_rsp_valid |=> !o_rsp_valid) else $error("answer too long");
   exc_code_a: assert property (o_rsp_valid |-> (o_rsp_exc ?
      (o_rsp_exc_code == 8'h02 && !o_rsp_bit) : o_rsp_exc_code == 8'h00))
      else $error("bad exception code");
   cmd_answer_a: assert property (o_cmd_valid |-> o_rsp_valid && !o_rsp_exc
      && o_rsp_bit == o_cmd_on) else $error("command without answer");
   unit_range_a: assert property (o_cmd_valid |-> o_cmd_unit >= 8'h01
      && o_cmd_unit <= 8'(NUM_UNITS)) else $error("command unit out of range");
   bad_func_a: assert property (take && !(i_req_func inside {8'h02, 8'h05, 8'h0F})
      |-> ##2 o_rsp_exc) else $error("bad function accepted");
   read_nocmd_a: assert property (take && i_req_func == 8'h02 |-> ##2 !o_cmd_valid)
      else $error("read made a command");
   energise_a: assert property (wr && i_req_wdata != 16'h0000 |-> ##2
      (o_rsp_exc || o_rsp_bit)) else $error("nonzero write not energised");
   deenergise_a: assert property (wr && i_req_wdata == 16'h0000 |-> ##2 !o_rsp_bit)
      else $error("zero write energised");
   pair_map_a: assert property (pair_p) else $error("pair coil mapped wrong");
   alias_map_a: assert property (alias_p) else $error("alias coil mapped wrong");

   cover property (wr ##2 o_cmd_valid);
   cover property (o_rsp_valid && o_rsp_exc);
   cover property (take && i_req_func == 8'h02 ##2 o_rsp_bit);
endmodule

bind fpm_point_map fpm_point_map_properties #(.NUM_UNITS(NUM_UNITS)) i_props
(
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
   .i_req_func(i_req_func), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
   .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_bit(o_rsp_bit),
   .o_rsp_exc(o_rsp_exc), .o_rsp_exc_code(o_rsp_exc_code), .o_cmd_valid(o_cmd_valid),
   .o_cmd_unit(o_cmd_unit), .o_cmd_relay(o_cmd_relay), .o_cmd_on(o_cmd_on)
);
`default_nettype wire

// File: tb/fpm_host_model.sv
// Host model: one point request at a time, held until taken
`timescale 1ns/10ps
`default_nettype none
module fpm_host_model
(
   input  wire logic   i_clk,
   input  wire logic   i_ready,
   input  wire logic   i_rsp_valid,
   output logic        o_valid,
   output logic [7:0]  o_func,
   output logic [15:0] o_addr,
   output logic [15:0] o_wdata
);
   initial
   begin
      o_valid = 1'b0;
      o_func = 8'h00;
      o_addr = 16'h0000;
      o_wdata = 16'h0000;
   end
   // Fields are scrambled once taken so a stale value cannot pass for a request
   task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                       input int gap, output int lat);
      repeat (gap + 1) @(posedge i_clk);
      o_valid <= 1'b1;
      o_func <= f;
      o_addr <= a;
      o_wdata <= d;
      lat = 0;
      @(negedge i_clk);
      while (i_ready !== 1'b1 && lat < 8)
      begin
         @(negedge i_clk);
         lat++;
      end
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_func <= ~f;
      o_addr <= ~a;
      o_wdata <= ~d;
      lat = 0;
      do
      begin
         @(negedge i_clk);
         lat++;
      end
      while (i_rsp_valid !== 1'b1 && lat < 8);
   endtask
endmodule
`default_nettype wire

// File: tb/test_fpm_point_map.sv
// Self-checking testbench for the field unit point map decoder
`timescale 1ns/10ps
`default_nettype none
module test_fpm_point_map;
   logic        clk;
   logic        rst_n;
   logic        req_valid;
   logic [7:0]  req_func;
   logic [15:0] req_addr;
   logic [15:0] req_wdata;
   logic        req_ready;
   logic        rsp_valid;
   logic        rsp_bit;
   logic        rsp_exc;
   logic [7:0]  rsp_code;
   logic        fld_wr;
   logic [7:0]  fld_unit;
   logic [6:0]  fld_alarm;
   logic [3:0]  fld_relay;
   logic        fld_gp;
   logic        cmd_valid;
   logic [7:0]  cmd_unit;
   logic [1:0]  cmd_relay;
   logic        cmd_on;
   logic [1:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        irq;
   logic        en;
   int          fail_count;
   int          n_compared;

   fpm_point_map i_dut
   (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_req_valid(req_valid), .i_req_func(req_func),
      .i_req_addr(req_addr), .i_req_wdata(req_wdata), .o_req_ready(req_ready),
      .o_rsp_valid(rsp_valid), .o_rsp_bit(rsp_bit), .o_rsp_exc(rsp_exc),
      .o_rsp_exc_code(rsp_code), .i_fld_wr(fld_wr), .i_fld_unit(fld_unit),
      .i_fld_alarm(fld_alarm), .i_fld_relay(fld_relay), .i_fld_gp(fld_gp),
      .o_cmd_valid(cmd_valid), .o_cmd_unit(cmd_unit), .o_cmd_relay(cmd_relay),
      .o_cmd_on(cmd_on), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
      .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_irq(irq)
   );
   fpm_host_model i_host
   (
      .i_clk(clk), .i_ready(req_ready), .i_rsp_valid(rsp_valid), .o_valid(req_valid),
      .o_func(req_func), .o_addr(req_addr), .o_wdata(req_wdata)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop;
      if (fail_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask

   // One host access; pacing varies with the low address bits
   task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                      input logic b, input logic e);
      int lat;
      i_host.xfer(f, a, d, int'(a[1:0]), lat);
      chk(16'(lat), 16'h0002);
      chk(16'(rsp_bit), 16'(b));
      chk(16'(rsp_exc), 16'(e));
      chk(16'(rsp_code), e ? 16'h0002 : 16'h0000);
      chk(16'(cmd_valid), 16'(!e && f != 8'h02 && en));
   endtask

   task automatic wc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                     input logic [7:0] u, input logic [1:0] r);
      acc(f, a, d, d != 16'h0000, 1'b0);
      chk(16'(cmd_unit), 16'(u));
      chk(16'(cmd_relay), 16'(r));
      chk(16'(cmd_on), 16'(d != 16'h0000));
   endtask

   task automatic fld(input logic [7:0] u, input logic [6:0] al, input logic [3:0] rl,
                      input logic gp);
      @(posedge clk);
      fld_wr <= 1'b1;
      fld_unit <= u;
      fld_alarm <= al;
      fld_relay <= rl;
      fld_gp <= gp;
      @(posedge clk);
      fld_wr <= 1'b0;
      fld_unit <= ~u;
   endtask

   task automatic rw(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rr(input logic [1:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, exp);
   endtask

   // Groups of 240: alarms 22..28, then relay 4, 1, 3, 2 status
   task automatic scan(input logic [7:0] u, input logic [10:0] exp);
      for (int g = 0; g < 11; g++)
         acc(8'h02, 16'h3E90 + 16'(g) * 16'h00F0 + 16'(u), 16'h0000, exp[g], 1'b0);
   endtask

   task automatic t_reset;
      rr(2'h0, 16'h0001);
      rr(2'h1, 16'h0000);
      rr(2'h2, 16'h0000);
      rr(2'h3, 16'h0000);
      chk(16'(req_ready), 16'h0001);
      chk(16'(irq), 16'h0000);
      scan(8'h05, 11'h000);
   endtask

   task automatic t_points;
      fld(8'h01, 7'h55, 4'h5, 1'b1);
      fld(8'hF0, 7'h2A, 4'hA, 1'b1);
      scan(8'h01, 11'h355);
      scan(8'hF0, 11'h4AA);
      fld(8'hF0, 7'h2A, 4'hA, 1'b0);
      scan(8'hF0, 11'h02A);
   endtask

   task automatic t_coils;
      wc(8'h05, 16'h0021, 16'hFF00, 8'h01, 2'h0);
      wc(8'h0F, 16'h0200, 16'h0000, 8'hF0, 2'h1);
      wc(8'h05, 16'h0022, 16'h0001, 8'h01, 2'h1);
      wc(8'h05, 16'h0201, 16'hFF00, 8'h01, 2'h1);
      wc(8'h0F, 16'h02F7, 16'h8000, 8'h07, 2'h2);
      wc(8'h05, 16'h04D0, 16'hFF00, 8'hF0, 2'h0);
      wc(8'h05, 16'h04D1, 16'h0000, 8'h01, 2'h3);
      wc(8'h05, 16'h05C0, 16'h00FF, 8'hF0, 2'h3);
   endtask

   // Unit 0, unit 241, coil edges, wrong function for the range, unknown functions
   task automatic t_illegal;
      logic [23:0] bad [8] = '{24'h023E90, 24'h0248E1, 24'h050020, 24'h0F05C1,
                               24'h020021, 24'h053E91, 24'h010021, 24'h033E91};
      foreach (bad[i])
         acc(bad[i][23:16], bad[i][15:0], 16'hFF00, 1'b0, 1'b1);
   endtask

   task automatic t_regs;
      rr(2'h1, 16'h0007);
      rr(2'h3, 16'h07F0);
      rw(2'h3, 16'h0000);
      rr(2'h3, 16'h07F0);
      chk(16'(irq), 16'h0000);
      rw(2'h2, 16'h0002);
      repeat (2) @(negedge clk);
      chk(16'(irq), 16'h0001);
      rw(2'h1, 16'h0002);
      repeat (2) @(negedge clk);
      chk(16'(irq), 16'h0000);
      rr(2'h1, 16'h0005);
      acc(8'h01, 16'h0021, 16'h0000, 1'b0, 1'b1);
      chk(16'(irq), 16'h0001);
      rw(2'h0, 16'h0000);
      en = 1'b0;
      acc(8'h05, 16'h0021, 16'hFF00, 1'b1, 1'b0);
      rw(2'h0, 16'h0001);
      en = 1'b1;
   endtask

   initial
   begin
      rst_n = 1'b0;
      fld_wr = 1'b0;
      fld_unit = 8'h00;
      fld_alarm = 7'h00;
      fld_relay = 4'h0;
      fld_gp = 1'b0;
      reg_addr = 2'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      en = 1'b1;
      fail_count = 0;
      n_compared = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_points();
      t_coils();
      t_illegal();
      t_regs();
      report_and_stop();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
